// File: verilog/tsa_pkg.sv
// Purpose: Shared constants for the two-step converter digital control and output stage
// Assumes: Coarse and fine comparator banks arrive already encoded as binary codes
// Notes:   Every width, offset and reset value shared by the verilog files lives here

package tsa_pkg;

    // ************************************************************
    // Code widths and correction arithmetic
    // ************************************************************
    localparam int          CODE_W     = 10;        // Converted word width
    localparam int          COARSE_W   = 6;         // Coarse step code, 0..63
    localparam int          FINE_W     = 6;         // Fine code, 0..63
    localparam int          SUM_W      = 13;        // Signed corrected sum width
    localparam int          STEP_SHIFT = 5;         // One coarse step is 32 LSB
    localparam int          CORR_LSB   = 16;        // Redundancy either side of a step
    localparam logic [SUM_W-1:0] SUM_CODE_MAX = 13'h03FF; // Top code, 1023
    localparam logic [SUM_W-1:0] SUM_CORR     = 13'h0010; // Fine offset, 16 LSB

    // ************************************************************
    // Latency and reset values
    // ************************************************************
    localparam int          LATENCY_DEF = 3;        // Rising edges from sample to output
    localparam logic [CODE_W-1:0] CODE_RST = 10'h000;
    localparam logic [CODE_W-1:0] CODE_TOP = 10'h3FF;

endpackage

// File: verilog/tsa_word_if.sv
// Purpose: Carrier for one corrected conversion word with its flags
// Assumes: Used only between the control top and its delay line
// Notes:   Source drives, sink consumes, no back-pressure

`timescale 1ns/10ps

interface tsa_word_if;
    logic                        valid;
    logic [tsa_pkg::CODE_W-1:0]  code;
    logic                        above;
    logic                        below;

    modport src (output valid, output code, output above, output below);
    modport dst (input  valid, input  code, input  above, input  below);
endinterface

// File: verilog/tsa_delay_line.sv
// Purpose: Fixed-length register delay line for corrected conversion words
// Assumes: DEPTH is at least one
// Notes:   Output word comes straight from the last stage register

`timescale 1ns/10ps

module tsa_delay_line #(
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst_b,
    // Word in and out
    tsa_word_if.dst     word_in,
    tsa_word_if.src     word_out
);

    localparam int WW = tsa_pkg::CODE_W + 3;

    logic [WW-1:0] word_flat;

    // Pack the incoming word into one vector
    assign word_flat = {word_in.valid, word_in.code, word_in.above, word_in.below};

    // ************************************************************
    // One register per stage
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_stage
            logic [WW-1:0] q;
            logic [WW-1:0] d;
            // First stage takes the incoming word, the rest the stage before
            if (g == 0) begin : g_head
                assign d = word_flat;
            end else begin : g_tail
                assign d = g_stage[g-1].q;
            end
            // Shift the word one stage on every rising edge
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    q <= '0;
                end else begin
                    q <= d;
                end
            end
        end
    endgenerate

    assign {word_out.valid, word_out.code, word_out.above, word_out.below} = g_stage[DEPTH-1].q;

endmodule

// File: verilog/tsa_adc_ctrl.sv
// Purpose: Digital control and output stage of a 10-bit two-step parallel converter
// Assumes: All inputs but rst_b synchronous to clk; open control pins are pulled high at the pad
// Notes:   Code and flag outputs are three-state at the pad, steered by the *_oe_b enables (low drives)

`timescale 1ns/10ps

// How it works
// R1: Rising edge latches coarse step code
// R2: Falling edge latches fine code, merges coarse
// R3: Corrects coarse errors up to sixteen LSB
// R4: Code and flags change on rising edge
// R5: Result appears LATENCY rising edges after sampling
// R6: Low MSB control inverts top bit
// R7: Low low-bits control inverts nine bits
// R8: Both high gives straight binary 0..1023
// R9: Outputs float unless output enable low
// R10: Power save needs request and enable high
// R11: Above-range flag when input exceeds top
// R12: Below-range flag when input under bottom
// R13: Range flags ignore polarity controls
// R14: Sample-and-hold settled by falling edge
// R15: Clock phases exceed minimum high, low
// R16: Power save invalidates outputs until latency passes
module tsa_adc_ctrl #(
    parameter int LATENCY = tsa_pkg::LATENCY_DEF
) (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           rst_b,
    // Comparator bank results
    input  wire logic [tsa_pkg::COARSE_W-1:0]   coarse_analog_in,
    input  wire logic [tsa_pkg::FINE_W-1:0]     fine_analog_in,
    // Format and power controls
    input  wire logic                           msb_polarity_ctl,
    input  wire logic                           low_bits_polarity_ctl,
    input  wire logic                           output_enable_b,
    input  wire logic                           power_save_req,
    // Converted word and range flags
    output logic [tsa_pkg::CODE_W-1:0]          conv_code_out,
    output logic                                above_range,
    output logic                                below_range,
    output logic                                conv_valid,
    // Output drivers and status
    output logic                                code_oe_b,
    output logic                                flag_oe_b,
    output logic                                power_save_active
);

    localparam int SW    = tsa_pkg::SUM_W;
    localparam int CW    = tsa_pkg::CODE_W;
    localparam int DEPTH = LATENCY - 1;     // Line stages; the output register adds one

    // ************************************************************
    // Power save
    // ************************************************************
    logic                         save_mode;

    // Entry needs request and enable both high; request alone is ignored
    // Save only gates the outputs here; analog power-down is outside
    assign save_mode = power_save_req & output_enable_b;             // [R10]

    // Save status mirrors the entry condition one edge late
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            power_save_active <= 1'b0;
        end else begin
            power_save_active <= save_mode;                          // [R10]
        end
    end

    // ************************************************************
    // Front end: coarse and fine comparator capture
    // ************************************************************
    logic [tsa_pkg::COARSE_W-1:0] coarse_q;
    logic [SW-1:0]                next_sum;
    logic                         sum_under;
    logic                         sum_over;
    logic [CW-1:0]                clamp_code;
    logic [CW-1:0]                fine_code;
    logic                         fine_above;
    logic                         fine_below;

    // Coarse step held for the whole conversion
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            coarse_q <= '0;
        end else begin
            coarse_q <= coarse_analog_in;                            // [R1]
        end
    end

    // Corrected sum: coarse step times 32 plus fine minus 16
    // A coarse step one off is absorbed by the fine redundancy
    always_comb begin
        next_sum = (SW'(coarse_q) << tsa_pkg::STEP_SHIFT)
                 + SW'(fine_analog_in) - tsa_pkg::SUM_CORR;          // [R3]
    end

    // Clamp ahead of the latch; a negative sum shows in the sign bit,
    // and the widest sum (63 steps plus 47) stays clear of it
    always_comb begin
        sum_under = next_sum[SW-1];                                  // [R12]
        sum_over  = !sum_under && (next_sum > tsa_pkg::SUM_CODE_MAX); // [R11]
        if (sum_under) begin
            clamp_code = tsa_pkg::CODE_RST;
        end else if (sum_over) begin
            clamp_code = tsa_pkg::CODE_TOP;
        end else begin
            clamp_code = next_sum[CW-1:0];
        end
    end

    // Fine capture on the falling edge, merged with the held coarse step
    always_ff @(negedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fine_code  <= tsa_pkg::CODE_RST;
            fine_above <= 1'b0;
            fine_below <= 1'b0;
        end else begin
            fine_code  <= clamp_code;                                // [R2]
            fine_above <= sum_over;
            fine_below <= sum_under;
        end
    end

    // ************************************************************
    // Latency pipeline
    // ************************************************************
    tsa_word_if pipe_in ();
    tsa_word_if pipe_out ();

    // Word enters the line on the rising edge after the fine latch;
    // from here on everything lives on the rising edge
    assign pipe_in.valid = ~save_mode;                               // [R16]
    assign pipe_in.code  = fine_code;
    assign pipe_in.above = fine_above;
    assign pipe_in.below = fine_below;

    tsa_delay_line #(
        .DEPTH    (DEPTH)
    ) u_delay (
        .clk      (clk),
        .rst_b    (rst_b),
        .word_in  (pipe_in.dst),
        .word_out (pipe_out.src)
    );                                                               // [R5]

    // ************************************************************
    // Output formatting
    // ************************************************************
    logic                         word_live;
    logic                         msb_flip;
    logic                         low_flip;
    logic [CW-1:0]                next_code;
    logic                         next_valid;
    logic                         next_above;
    logic                         next_below;

    // Shown only if valid on entry and save is still off at the output
    assign word_live = pipe_out.valid & ~save_mode;                  // [R16]

    // A low control pin asks for inversion of its bit group
    assign msb_flip = ~msb_polarity_ctl;                             // [R6]
    assign low_flip = ~low_bits_polarity_ctl;                        // [R7]

    // Format the word; both controls high leaves straight binary
    // Controls are used as they stand at the output edge
    always_comb begin
        next_code  = tsa_pkg::CODE_RST;
        next_valid = 1'b0;
        next_above = 1'b0;
        next_below = 1'b0;
        if (word_live) begin
            next_code[CW-1]   = pipe_out.code[CW-1] ^ msb_flip;      // [R6] [R8]
            next_code[CW-2:0] = pipe_out.code[CW-2:0] ^ {(CW-1){low_flip}}; // [R7] [R8]
            next_valid        = 1'b1;
            next_above        = pipe_out.above;                      // [R13]
            next_below        = pipe_out.below;                      // [R13]
        end
    end

    // ************************************************************
    // Output registers
    // ************************************************************

    // Code and valid move only on the rising edge; blank while not valid
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            conv_code_out <= tsa_pkg::CODE_RST;
            conv_valid    <= 1'b0;
        end else begin
            conv_code_out <= next_code;                              // [R4]
            conv_valid    <= next_valid;                             // [R16]
        end
    end

    // Flags keep fixed polarity whatever the format
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            above_range <= 1'b0;
            below_range <= 1'b0;
        end else begin
            above_range <= next_above;                               // [R13] [R4]
            below_range <= next_below;                               // [R13]
        end
    end

    // ************************************************************
    // Pad drivers
    // ************************************************************

    // Pads follow output enable one edge late; float under reset
    // An unwired enable pin reads high at the pad, so the pads float
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            code_oe_b <= 1'b1;
            flag_oe_b <= 1'b1;
        end else begin
            code_oe_b <= output_enable_b;                            // [R9]
            flag_oe_b <= output_enable_b;                            // [R9]
        end
    end

endmodule

// File: tb/tsa_adc_ctrl_asserts.sv
// Purpose: Port-level checks for the converter control block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Attached by bind from the bench
`timescale 1ns/10ps
module tsa_adc_ctrl_asserts #(
    parameter int LATENCY = 3
) (
    // Clock, reset and controls
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       msb_polarity_ctl,
    input wire logic       low_bits_polarity_ctl,
    input wire logic       output_enable_b,
    input wire logic       power_save_req,
    // Results and pad status
    input wire logic [9:0] conv_code_out,
    input wire logic       above_range,
    input wire logic       below_range,
    input wire logic       conv_valid,
    input wire logic       code_oe_b,
    input wire logic       flag_oe_b,
    input wire logic       power_save_active
);
    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_oe_code; 1'b1 |=> code_oe_b == $past(output_enable_b); endproperty
    a_oe_code: assert property (p_oe_code) else $error("code enable wrong");
    property p_oe_flag; 1'b1 |=> flag_oe_b == $past(output_enable_b); endproperty
    a_oe_flag: assert property (p_oe_flag) else $error("flag enable wrong");
    property p_save; power_save_req && output_enable_b |=> power_save_active; endproperty
    a_save: assert property (p_save) else $error("save not entered");
    property p_no_save; !output_enable_b |=> !power_save_active; endproperty
    a_no_save: assert property (p_no_save) else $error("save while driven");
    property p_invalid_zero; !conv_valid |-> conv_code_out == 10'h000 && !above_range
        && !below_range; endproperty
    a_invalid_zero: assert property (p_invalid_zero) else $error("invalid word shown");
    property p_save_invalid; power_save_req && output_enable_b |=> !conv_valid; endproperty
    a_save_invalid: assert property (p_save_invalid) else $error("valid in save");
    property p_save_flush; power_save_req && output_enable_b |-> ##LATENCY !conv_valid;
    endproperty
    a_save_flush: assert property (p_save_flush) else $error("save word shown");
    property p_above_code; above_range |-> conv_code_out == (10'h3FF ^
        {~$past(msb_polarity_ctl), {9{~$past(low_bits_polarity_ctl)}}}); endproperty
    a_above_code: assert property (p_above_code) else $error("top code wrong");
    property p_below_code; below_range |-> !above_range && conv_code_out ==
        {~$past(msb_polarity_ctl), {9{~$past(low_bits_polarity_ctl)}}}; endproperty
    a_below_code: assert property (p_below_code) else $error("bottom code wrong");
endmodule

// File: tb/tsa_sh_model.sv
// Purpose: Sample-and-hold stage feeding the comparator banks
// Assumes: Requests change shortly after a rising edge
// Notes:   Fine level glitches before it settles
`timescale 1ns/10ps
module tsa_hold_model (
    // Requested levels
    input  wire logic [5:0] c_req,
    input  wire logic [5:0] f_req,
    // Comparator bank levels
    output logic      [5:0] coarse,
    output logic      [5:0] fine
);
    // Coarse follows at once
    assign coarse = c_req;
    // Fine rings for 1 ns and settles 0.5 ns before the falling edge
    always begin
        fine = ~f_req;
        #1 fine = f_req;
        @(f_req);
    end
endmodule

// File: tb/tsa_adc_ctrl_bench.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Default latency; a request lands one edge after it is set
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/10ps
module tsa_adc_ctrl_bench;
    logic       clk = 1'b0;
    logic       rst_b, msb_polarity_ctl, low_bits_polarity_ctl, output_enable_b, power_save_req;
    logic [5:0] c_req, f_req, coarse, fine;
    logic [9:0] conv_code_out;
    logic       above_range, below_range, conv_valid, code_oe_b, flag_oe_b, power_save_active;
    int         failures = 0;
    int         comparisons = 0;
    localparam int LAT = tsa_pkg::LATENCY_DEF;
    // Clock at 200 MHz
    always #2.5 clk = ~clk;
    tsa_hold_model u_hold (.c_req(c_req), .f_req(f_req), .coarse(coarse), .fine(fine));
    tsa_adc_ctrl #(.LATENCY(LAT)) DUT (.clk(clk), .rst_b(rst_b), .coarse_analog_in(coarse),
        .fine_analog_in(fine), .msb_polarity_ctl(msb_polarity_ctl),
        .low_bits_polarity_ctl(low_bits_polarity_ctl), .output_enable_b(output_enable_b),
        .power_save_req(power_save_req), .conv_code_out(conv_code_out),
        .above_range(above_range), .below_range(below_range), .conv_valid(conv_valid),
        .code_oe_b(code_oe_b), .flag_oe_b(flag_oe_b), .power_save_active(power_save_active));
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One sample, checked after the latency
    task automatic conv(input logic [5:0] c, input logic [5:0] f);
        int         v;
        logic [9:0] e;
        v = c * 32 + f - 16;
        e = (v < 0) ? 10'h000 : (v > 1023) ? 10'h3FF : v[9:0];
        e = e ^ {~msb_polarity_ctl, {9{~low_bits_polarity_ctl}}};
        c_req = c;
        f_req = f;
        repeat (LAT + 1) @(posedge clk); // coarse is taken at the first edge
        #1 chk({3'h0, conv_valid, above_range, below_range, conv_code_out},
            {3'h0, 1'b1, v > 1023, v < 0, e});
    endtask
    // Pad status after one edge
    task automatic pads(input logic [2:0] exp);
        @(posedge clk);
        #1 chk({13'h0, code_oe_b, flag_oe_b, power_save_active}, {13'h0, exp});
    endtask
    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        {rst_b, c_req, f_req, output_enable_b, power_save_req} = '0;
        {msb_polarity_ctl, low_bits_polarity_ctl} = 2'h3;
        repeat (16) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        for (int k = 0; k < 4; k++) begin
            {msb_polarity_ctl, low_bits_polarity_ctl} = 2'(3 - k);
            conv(6'h10, 6'h10);
            conv(6'h0F, 6'h30);
            conv(6'h00, 6'h00);
            conv(6'h20, 6'h2F);
            conv(6'h1F, 6'h2F);
        end
        output_enable_b = 1'b1;
        pads(3'h6);
        power_save_req = 1'b1;
        pads(3'h7);
        repeat (2) @(posedge clk);
        #1 chk({3'h0, conv_valid, above_range, below_range, conv_code_out}, 16'h0000);
        output_enable_b = 1'b0;
        pads(3'h0);
        chk({15'h0, conv_valid}, 16'h0000);
        conv(6'h08, 6'h21);
        conclude();
    end
    // Watchdog
    initial begin
        #5000;
        failures++;
        conclude();
    end
endmodule
bind tsa_adc_ctrl tsa_adc_ctrl_asserts #(.LATENCY(LATENCY)) u_chk (.clk(clk), .rst_b(rst_b),
    .msb_polarity_ctl(msb_polarity_ctl), .low_bits_polarity_ctl(low_bits_polarity_ctl),
    .output_enable_b(output_enable_b), .power_save_req(power_save_req),
    .conv_code_out(conv_code_out), .above_range(above_range), .below_range(below_range),
    .conv_valid(conv_valid), .code_oe_b(code_oe_b), .flag_oe_b(flag_oe_b),
    .power_save_active(power_save_active));
